// *** rtl/mct_match_teach.sv ***
`default_nettype none
`include "mct_params.svh"
// Behaviour
// - length counts used characters, check digit suppressed
// - length derived from element counts per symbology
// - ean fixed 13 or 8, own enables
// - upc fixed 12 or 6, own enables
// - expanded symbologies may emit extra characters
// - compare each read against two references
// - result on assigned outputs and beeper
// - lamp only on match, held one pulse
// - output filter passes exact matches only
// - reference max 50 chars, 32..137, evaluable
// - teach stores type, length, content persistently
// - input activation holds until power off
// - dynamic teach keeps enabled symbologies, manual pulse
// - static teach opens and closes pulse itself
// - after static teach lock other symbologies
// - static teach forces 30 reads, restores on miss
// - counter reset option clears daily counters on static teach commit
// - two persistent eight digit counters, query only
// - configured comparison outranks teach input
// - reference two only from configuration
// - teach input falling edge enters teach
// - teach input rising commits and compares
module mct_match_teach
  import mct_pkg::*;
#(
  parameter int MAX_LEN = `MCT_REF_MAX_LEN
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // configuration
  input  wire mct_teach_mode_t      teach_mode,
  input  wire logic                 cfg_cmp_en,
  input  wire logic                 cfg_filter_en,
  input  wire logic                 cfg_counter_reset,
  input  wire logic [9:0]           sym_enable,
  input  wire logic                 ean13_en,
  input  wire logic                 ean8_en,
  input  wire logic                 upc_a_en,
  input  wire logic                 upc_e_en,
  input  wire logic [5:0]           cfg_multi_reads,
  input  wire logic [2:0]           result_sel,
  input  wire logic                 beeper_sel,
  // host writes of reference codes
  input  wire logic                 ref_wr,
  input  wire logic                 ref_wr_sel,
  input  wire mct_sym_t             ref_wr_sym,
  input  wire logic [5:0]           ref_wr_len,
  input  wire logic [5:0]           ref_wr_idx,
  input  wire logic [7:0]           ref_wr_char,
  input  wire logic                 ref2_en,
  // teach-in switching input, high when energized
  input  wire logic                 teach_in,
  // reading pulse and decoded label stream
  input  wire logic                 pulse_ext,
  input  wire logic                 lbl_start,
  input  wire mct_sym_t             lbl_sym,
  input  wire logic                 lbl_char_vld,
  input  wire logic [7:0]           lbl_char,
  input  wire logic                 lbl_chk_digit,
  input  wire logic                 lbl_end,
  input  wire logic                 lbl_good,
  // element counts for length derivation
  input  wire logic [7:0]           elem_count,
  output logic [5:0]                derived_len,
  // outputs
  output logic                      pulse_active,
  output logic [5:0]                multi_reads,
  output logic                      host_pass,
  output logic                      host_char_vld,
  output logic [7:0]                host_char,
  output logic [2:0]                result_out,
  output logic                      beeper,
  output logic                      result_lamp,
  output logic                      nv_commit,
  output logic                      daily_clear,
  // persistent counters, read by the query string handler
  input  wire logic                 persistent_counter_query,
  output logic [31:0]               good_count,
  output logic [31:0]               noread_count
);
  typedef struct packed {
    mct_state_t        st;
    logic              teach_prev;
    logic              cmp_active;
    logic              static_lock;
    logic              auto_pulse;
    mct_sym_t          r1_sym;
    logic [5:0]        r1_len;
    mct_sym_t          r2_sym;
    logic [5:0]        r2_len;
    mct_sym_t          cap_sym;
    logic [5:0]        cap_len;
    logic              cap_ok;
    logic [5:0]        cur_len;
    logic              m1_ok;
    logic              m2_ok;
    logic              bad_char;
    logic              pulse_match;
    logic              pulse_read;
    logic              lamp;
    logic              pulse_prev;
    logic [2:0]        res;
    logic              beep;
    logic              pass;
    logic              hvld;
    logic [7:0]        hchar;
    logic              commit;
    logic              dclr;
  } mct_state_s_t;

  mct_state_s_t s_reg;
  mct_state_s_t s_next;

  // reference and capture character storage
  logic [7:0] ref1_mem [MAX_LEN];
  logic [7:0] ref2_mem [MAX_LEN];
  logic [7:0] cap_mem  [MAX_LEN];

  logic pulse;
  logic pulse_end;
  logic teach_fall;
  logic teach_rise;
  logic char_legal;
  logic len_room;
  logic sym_ok;
  logic fixed_ok;
  logic lbl_match1;
  logic lbl_match2;
  logic cnt_good_inc;
  logic cnt_noread_inc;

  assign pulse      = pulse_ext | s_reg.auto_pulse;
  assign pulse_end  = s_reg.pulse_prev & ~pulse;
  assign teach_fall = s_reg.teach_prev & ~teach_in;
  assign teach_rise = ~s_reg.teach_prev & teach_in;
  assign char_legal = lbl_char >= `MCT_CHAR_MIN
                      && lbl_char <= `MCT_CHAR_MAX;
  assign len_room   = s_reg.cur_len < 6'(MAX_LEN);

  // fixed-length symbologies only take their enabled lengths
  always_comb begin
    unique case (lbl_sym)
      MCT_SYM_EAN: fixed_ok = (ean13_en && s_reg.cur_len == `MCT_LEN_EAN_NORM)
                   || (ean8_en && s_reg.cur_len == `MCT_LEN_EAN_SHORT);
      MCT_SYM_UPC: fixed_ok = (upc_a_en && s_reg.cur_len == `MCT_LEN_UPC_A)
                   || (upc_e_en && s_reg.cur_len == `MCT_LEN_UPC_E);
      default:     fixed_ok = 1'b1;
    endcase
  end

  // static teach accepts any implemented symbology, otherwise enabled only
  assign sym_ok = lbl_sym != MCT_SYM_NONE
                  && (sym_enable[lbl_sym] || s_reg.st == MCT_ST_CAPTURE
                      && teach_mode != MCT_TEACH_DYNAMIC);

  // length derivation from element counts
  always_comb begin
    unique case (lbl_sym)
      MCT_SYM_C39:  derived_len = 6'((elem_count - `MCT_C39_OFS) / `MCT_C39_DIV);
      MCT_SYM_I25:  derived_len = 6'((elem_count - `MCT_I25_OFS) / `MCT_I25_DIV);
      MCT_SYM_CBR:  derived_len = 6'((elem_count - `MCT_CBR_OFS) / `MCT_CBR_DIV);
      MCT_SYM_C128, MCT_SYM_EAN128:
        derived_len = 6'((elem_count - `MCT_C128_OFS) / `MCT_C128_DIV);
      MCT_SYM_PHARMA: derived_len = elem_count[5:0];
      default:      derived_len = 6'h00;
    endcase
  end

  // a label matches when type, length and every character agree
  assign lbl_match1 = s_reg.m1_ok && lbl_sym == s_reg.r1_sym
                      && s_reg.cur_len == s_reg.r1_len;
  assign lbl_match2 = ref2_en && s_reg.m2_ok && lbl_sym == s_reg.r2_sym
                      && s_reg.cur_len == s_reg.r2_len;

  // storage writes; reference one may be rewritten by the host, which
  // is expected to leave a taught code alone until power-off
  always_ff @(posedge clock) begin
    if (ref_wr && ref_wr_idx < 6'(MAX_LEN)) begin
      if (ref_wr_sel) ref2_mem[ref_wr_idx] <= ref_wr_char;
      else            ref1_mem[ref_wr_idx] <= ref_wr_char;
    end else if (s_reg.st == MCT_ST_COMMIT) begin
      for (int i = 0; i < MAX_LEN; i++) ref1_mem[i] <= cap_mem[i];
    end
    // the check digit is part of the taught content and length
    if (s_reg.st == MCT_ST_CAPTURE && lbl_char_vld && len_room) begin
      cap_mem[s_reg.cur_len] <= lbl_char;
    end
  end

  // main sequencing
  always_comb begin
    s_next = s_reg;
    s_next.teach_prev = teach_in;
    s_next.pulse_prev = pulse;
    s_next.commit = 1'b0;
    s_next.dclr = 1'b0;
    s_next.hvld = 1'b0;
    s_next.res = 3'h0;
    s_next.beep = 1'b0;
    if (ref_wr && !ref_wr_sel) begin
      s_next.r1_sym = ref_wr_sym;
      s_next.r1_len = ref_wr_len;
    end
    if (ref_wr && ref_wr_sel) begin
      s_next.r2_sym = ref_wr_sym;
      s_next.r2_len = ref_wr_len;
    end
    // per-label character walk
    if (lbl_start) begin
      s_next.cur_len = 6'h00;
      s_next.m1_ok = 1'b1;
      s_next.m2_ok = 1'b1;
      s_next.bad_char = 1'b0;
    end
    // the check digit counts toward length but never reaches the host
    if (lbl_char_vld) begin
      s_next.cur_len = len_room ? s_reg.cur_len + 6'h01 : s_reg.cur_len;
      if (!char_legal || !len_room) s_next.bad_char = 1'b1;
      if (!len_room || ref1_mem[s_reg.cur_len] != lbl_char)
        s_next.m1_ok = 1'b0;
      if (!len_room || ref2_mem[s_reg.cur_len] != lbl_char)
        s_next.m2_ok = 1'b0;
      // expanded symbologies simply stream more characters
      s_next.hvld = !lbl_chk_digit;
      if (!lbl_chk_digit) s_next.hchar = lbl_char;
    end
    if (lbl_end && lbl_good && sym_ok && fixed_ok) begin
      s_next.pulse_read = 1'b1;
      if ((s_reg.cmp_active || cfg_cmp_en) && (lbl_match1 || lbl_match2))
        s_next.pulse_match = 1'b1;
      // filter and post-static lock gate host output
      s_next.pass = (!cfg_filter_en || lbl_match1 || lbl_match2)
                    && (!s_reg.static_lock || lbl_sym == s_reg.r1_sym
                        && s_reg.cur_len == s_reg.r1_len);
    end else if (lbl_start) begin
      s_next.pass = 1'b0;
    end
    // result at end of reading pulse
    if (pulse_end) begin
      s_next.res = result_sel & {3{s_reg.pulse_match}};
      s_next.beep = beeper_sel & s_reg.pulse_match;
      s_next.pulse_match = 1'b0;
      s_next.pulse_read = 1'b0;
      // lamp lights on a match and goes dark when the next unmatched pulse ends,
      // so it stays lit through at least one following pulse
      s_next.lamp = s_reg.pulse_match;
    end
    unique case (s_reg.st)
      MCT_ST_READ: begin
        if (teach_rise && teach_mode != MCT_TEACH_OFF && !cfg_cmp_en)
          s_next.cmp_active = 1'b1;
        if (teach_fall && teach_mode != MCT_TEACH_OFF) begin
          s_next.st = MCT_ST_CAPTURE;
          s_next.cap_ok = 1'b0;
          if (teach_mode != MCT_TEACH_DYNAMIC)
            s_next.auto_pulse = 1'b1;
        end
      end
      MCT_ST_CAPTURE: begin
        if (lbl_end && lbl_good && sym_ok && !s_reg.bad_char
            && (teach_mode != MCT_TEACH_STATIC_PH || lbl_sym != MCT_SYM_PHARMA
                || s_reg.cur_len >= `MCT_PHARMA_MIN_LEN)) begin
          s_next.cap_sym = lbl_sym;
          s_next.cap_len = s_reg.cur_len;
          s_next.cap_ok = 1'b1;
          s_next.auto_pulse = 1'b0;
          s_next.st = MCT_ST_HOLD;
        end else if (teach_rise) begin
          s_next.auto_pulse = 1'b0;   // nothing captured, keep old
          s_next.st = MCT_ST_READ;
        end
      end
      MCT_ST_HOLD: begin
        if (teach_rise) s_next.st = MCT_ST_COMMIT;
      end
      MCT_ST_COMMIT: begin
        s_next.r1_sym = s_reg.cap_sym;
        s_next.r1_len = s_reg.cap_len;
        s_next.commit = 1'b1;
        s_next.cmp_active = 1'b1;
        s_next.static_lock = teach_mode != MCT_TEACH_DYNAMIC;
        s_next.dclr = cfg_counter_reset
                      && teach_mode != MCT_TEACH_DYNAMIC;
        s_next.st = MCT_ST_READ;
      end
      default: s_next.st = MCT_ST_READ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.teach_prev <= 1'b0;   // an open switch at power-up is no edge
    end else begin
      s_reg <= s_next;
    end
  end

  assign cnt_good_inc   = pulse_end && s_reg.pulse_read;
  assign cnt_noread_inc = pulse_end && !s_reg.pulse_read;

  // non-volatile totals; not cleared by the daily reset
  mct_bcd_counter #(.DIGITS(`MCT_CNT_DIGITS)) u_good (
    .clock (clock),
    .rst   (rst),
    .inc   (cnt_good_inc),
    .clear (1'b0),
    .value (good_count)
  );
  mct_bcd_counter #(.DIGITS(`MCT_CNT_DIGITS)) u_noread (
    .clock (clock),
    .rst   (rst),
    .inc   (cnt_noread_inc),
    .clear (1'b0),
    .value (noread_count)
  );

  // static teach runs with the forced multi-read figure
  assign multi_reads   = (s_reg.st == MCT_ST_CAPTURE
                          && teach_mode != MCT_TEACH_DYNAMIC)
                         ? `MCT_STATIC_MULTI : cfg_multi_reads;
  assign pulse_active  = pulse;
  assign host_pass     = s_reg.pass;
  assign host_char_vld = s_reg.hvld;
  assign host_char     = s_reg.hchar;
  assign result_out    = s_reg.res;
  assign beeper        = s_reg.beep;
  assign result_lamp   = s_reg.lamp;
  assign nv_commit     = s_reg.commit;
  assign daily_clear   = s_reg.dclr;

  // lamp never lights without a matched pulse just ended
  property p_lamp_cause;
    @(posedge clock) disable iff (rst)
      $rose(result_lamp) |-> $past(s_reg.pulse_match) && $past(pulse_end);
  endproperty
  a_lamp_cause: assert property (p_lamp_cause) else $error("lamp no match");

  property p_commit;
    @(posedge clock) disable iff (rst)
      s_reg.st == MCT_ST_HOLD && teach_rise |-> ##2 nv_commit && s_reg.cmp_active;
  endproperty
  a_commit: assert property (p_commit) else $error("commit missing");

  property p_enter;
    @(posedge clock) disable iff (rst)
      s_reg.st == MCT_ST_READ && teach_fall && teach_mode != MCT_TEACH_OFF
      |=> s_reg.st == MCT_ST_CAPTURE;
  endproperty
  a_enter: assert property (p_enter) else $error("teach not entered");

  property p_cmp_hold;
    @(posedge clock) disable iff (rst) s_reg.cmp_active |=> s_reg.cmp_active;
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare dropped");

  property p_multi;
    @(posedge clock) disable iff (rst)
      s_reg.st == MCT_ST_CAPTURE && teach_mode == MCT_TEACH_STATIC
      |-> multi_reads == `MCT_STATIC_MULTI;
  endproperty
  a_multi: assert property (p_multi) else $error("multi reads wrong");

  property p_auto;
    @(posedge clock) disable iff (rst)
      s_reg.st == MCT_ST_READ && teach_fall && teach_mode == MCT_TEACH_STATIC
      |=> pulse_active;
  endproperty
  a_auto: assert property (p_auto) else $error("no auto pulse");

  property p_result;
    @(posedge clock) disable iff (rst)
      |result_out |-> $past(pulse_end) && $past(s_reg.pulse_match);
  endproperty
  a_result: assert property (p_result) else $error("result no cause");

  property p_dclr;
    @(posedge clock) disable iff (rst)
      daily_clear |-> $past(s_reg.st) == MCT_ST_COMMIT && cfg_counter_reset;
  endproperty
  a_dclr: assert property (p_dclr) else $error("stray daily clear");
endmodule
`default_nettype wire

// *** inc/mct_params.svh ***
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

`define MCT_REF_MAX_LEN      50
`define MCT_CHAR_MIN         8'h20
`define MCT_CHAR_MAX         8'h89
`define MCT_LEN_EAN_NORM     6'h0d
`define MCT_LEN_EAN_SHORT    6'h08
`define MCT_LEN_UPC_A        6'h0c
`define MCT_LEN_UPC_E        6'h06
`define MCT_C39_OFS          8'h0a
`define MCT_C39_DIV          8'h05
`define MCT_I25_OFS          8'h01
`define MCT_I25_DIV          8'h02
`define MCT_CBR_OFS          8'h08
`define MCT_CBR_DIV          8'h04
`define MCT_C128_OFS         8'h0a
`define MCT_C128_DIV         8'h03
`define MCT_STATIC_MULTI     6'h1e
`define MCT_PHARMA_MIN_LEN   6'h04
`define MCT_CNT_DIGITS       8
`define MCT_CNT_DIGIT_MAX    4'h9

`endif

// *** inc/mct_pkg.sv ***
`default_nettype none
package mct_pkg;
  // symbology codes carried with each decoded label
  typedef enum logic [3:0] {
    MCT_SYM_NONE, MCT_SYM_C39, MCT_SYM_I25, MCT_SYM_EAN, MCT_SYM_UPC,
    MCT_SYM_CBR, MCT_SYM_C128, MCT_SYM_C93, MCT_SYM_EAN128, MCT_SYM_PHARMA
  } mct_sym_t;

  typedef enum logic [1:0] {
    MCT_TEACH_OFF, MCT_TEACH_DYNAMIC, MCT_TEACH_STATIC, MCT_TEACH_STATIC_PH
  } mct_teach_mode_t;

  typedef enum logic [2:0] {
    MCT_ST_READ, MCT_ST_ARMED, MCT_ST_CAPTURE, MCT_ST_HOLD, MCT_ST_COMMIT
  } mct_state_t;
endpackage
`default_nettype wire

// *** rtl/mct_bcd_counter.sv ***
`default_nettype none
`include "mct_params.svh"
// persistent decimal counter, saturating at all nines
module mct_bcd_counter
  import mct_pkg::*;
#(
  parameter int DIGITS = `MCT_CNT_DIGITS
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // control
  input  wire logic              inc,
  input  wire logic              clear,
  // value
  output logic [4*DIGITS-1:0]    value
);
  typedef struct packed {
    logic [4*DIGITS-1:0] cnt;
  } mct_cnt_state_t;

  mct_cnt_state_t state_reg;
  mct_cnt_state_t state_next;
  logic [DIGITS:0] carry;
  logic            all_nines;

  // ripple decimal carry per digit
  assign carry[0] = inc & ~all_nines;
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_digit
      always_comb begin
        if (carry[g] && state_reg.cnt[4*g +: 4] == `MCT_CNT_DIGIT_MAX) begin
          state_next.cnt[4*g +: 4] = 4'h0;
          carry[g+1] = 1'b1;
        end else begin
          state_next.cnt[4*g +: 4] = state_reg.cnt[4*g +: 4] + {3'h0, carry[g]};
          carry[g+1] = 1'b0;
        end
      end
    end
  endgenerate

  // saturate rather than wrap so totals never look smaller
  assign all_nines = (state_reg.cnt == {DIGITS{`MCT_CNT_DIGIT_MAX}});

  always_ff @(posedge clock) begin
    if (rst || clear) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.cnt;
endmodule
`default_nettype wire

// *** verif/mct_operator.sv ***
`default_nettype none
// operator switch, trigger and decoded label stream in front of the block
module mct_operator
  import mct_pkg::*;
(
  // clock
  input  wire logic  clock,
  // operator side
  output logic       teach_in,
  output logic       pulse_ext,
  // label stream
  output logic       lbl_start,
  output mct_sym_t   lbl_sym,
  output logic       lbl_char_vld,
  output logic [7:0] lbl_char,
  output logic       lbl_chk_digit,
  output logic       lbl_end,
  output logic       lbl_good
);
  timeunit 1ns;
  timeprecision 1ns;

  // switch open at power-up, so the configured setting keeps priority
  initial begin
    teach_in = 1'b0;
    pulse_ext = 1'b0;
    lbl_start = 1'b0;
    lbl_sym = MCT_SYM_NONE;
    lbl_char_vld = 1'b0;
    lbl_char = 8'h00;
    lbl_chk_digit = 1'b0;
    lbl_end = 1'b0;
    lbl_good = 1'b0;
  end

  task automatic set_teach(input logic v);
    @(posedge clock);
    teach_in <= v;
  endtask

  // manual trigger, the only pulse source in dynamic teach
  task automatic set_pulse(input logic v);
    @(posedge clock);
    pulse_ext <= v;
  endtask

  task automatic set_sym(input mct_sym_t s);
    @(posedge clock);
    lbl_sym <= s;
  endtask

  // n data chars from base, then a check digit kept from the host
  // no minimum length is kept here, even for a pharma label offered for teach
  task automatic label(input mct_sym_t s, input logic [7:0] base,
                       input int n, input logic good);
    @(posedge clock);
    lbl_start <= 1'b1;
    lbl_sym <= s;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      lbl_start <= 1'b0;
      lbl_char_vld <= 1'b1;
      lbl_chk_digit <= (i == n);
      lbl_char <= (i == n) ? 8'h39 : base + 8'(i);
    end
    // released data line shows the inverse, never a stale value
    @(posedge clock);
    lbl_char_vld <= 1'b0;
    lbl_chk_digit <= 1'b0;
    lbl_char <= ~lbl_char;
    lbl_end <= 1'b1;
    lbl_good <= good;
    @(posedge clock);
    lbl_end <= 1'b0;
    lbl_good <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/mct_match_teach_test.sv ***
`default_nettype none
`include "mct_params.svh"
module mct_match_teach_test
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rst = 1'b1;
  mct_teach_mode_t teach_mode = MCT_TEACH_OFF;
  logic cmp_en = 1'b0, filt_en = 1'b0, cnt_rst = 1'b0;
  logic [9:0] sym_en = 10'h3ff;
  logic [5:0] mreads = 6'h01;
  logic [2:0] rsel = 3'h2;
  logic bsel = 1'b1, ref_wr = 1'b0, wsel = 1'b0, ref2_en = 1'b0;
  logic [5:0] widx = 6'h00;
  logic [7:0] wchar = 8'h20, elem = 8'h00;
  logic [3:0] fix_en = 4'hf;
  logic [5:0] wlen = 6'h06;
  mct_sym_t wsym = MCT_SYM_C39;
  wire logic teach_in, pulse_ext, lstart, lvld, lchk, lend, lgood;
  mct_sym_t lsym;
  logic [7:0] lchar, hchar;
  logic [5:0] dlen, mr_out;
  logic pact, hpass, hvld, beeper, lamp, nv, dclr;
  logic [2:0] rout;
  logic [31:0] gcnt, ncnt, n0;
  int err_count = 0, n_compared = 0, cyc = 0, h_n = 0, fl = 0;
  logic [2:0] r_seen;
  logic b_seen, nv_seen, clr_seen;

  always #50 clock = ~clock;

  mct_operator op (.clock(clock), .teach_in(teach_in),
    .pulse_ext(pulse_ext), .lbl_start(lstart), .lbl_sym(lsym),
    .lbl_char_vld(lvld), .lbl_char(lchar), .lbl_chk_digit(lchk),
    .lbl_end(lend), .lbl_good(lgood));

  mct_match_teach dut (.clock(clock), .rst(rst), .teach_mode(teach_mode),
    .cfg_cmp_en(cmp_en), .cfg_filter_en(filt_en),
    .cfg_counter_reset(cnt_rst), .sym_enable(sym_en), .ean13_en(fix_en[0]),
    .ean8_en(fix_en[1]), .upc_a_en(fix_en[2]), .upc_e_en(fix_en[3]),
    .cfg_multi_reads(mreads), .result_sel(rsel), .beeper_sel(bsel),
    .ref_wr(ref_wr), .ref_wr_sel(wsel), .ref_wr_sym(wsym),
    .ref_wr_len(wlen), .ref_wr_idx(widx), .ref_wr_char(wchar),
    .ref2_en(ref2_en), .teach_in(teach_in), .pulse_ext(pulse_ext),
    .lbl_start(lstart), .lbl_sym(lsym), .lbl_char_vld(lvld),
    .lbl_char(lchar), .lbl_chk_digit(lchk), .lbl_end(lend),
    .lbl_good(lgood), .elem_count(elem), .derived_len(dlen),
    .pulse_active(pact), .multi_reads(mr_out), .host_pass(hpass),
    .host_char_vld(hvld), .host_char(hchar), .result_out(rout),
    .beeper(beeper), .result_lamp(lamp), .nv_commit(nv),
    .daily_clear(dclr), .persistent_counter_query(1'b0),
    .good_count(gcnt), .noread_count(ncnt));

  // sticky catchers, so one-cycle pulses are not missed
  always @(negedge clock) begin
    r_seen = r_seen | rout;
    b_seen = b_seen | (beeper === 1'b1);
    nv_seen = nv_seen | (nv === 1'b1);
    clr_seen = clr_seen | (dclr === 1'b1);
    h_n = h_n + ((hvld === 1'b1) ? 1 : 0);
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic clr();
    r_seen = 3'h0;
    b_seen = 1'b0;
    nv_seen = 1'b0;
    clr_seen = 1'b0;
    h_n = 0;
  endtask

  // five chars plus check digit; ref one never written after teach
  task automatic wr_ref(input logic sel, input logic [7:0] base);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      ref_wr <= 1'b1;
      wsel <= sel;
      widx <= 6'(i);
      wchar <= (i == 5) ? 8'h39 : base + 8'(i);
    end
    @(posedge clock);
    ref_wr <= 1'b0;
  endtask

  // full reading pulse; n of zero gives a no-read
  task automatic rd(input mct_sym_t s, input logic [7:0] b, input int n);
    clr();
    op.set_pulse(1'b1);
    if (n > 0) op.label(s, b, n, 1'b1);
    repeat (2) @(posedge clock);
    op.set_pulse(1'b0);
    repeat (4) @(negedge clock);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clr();
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("rout", 3'h0, rout);
    chk("lamp", 1'b0, lamp);
    done("reset");
    // element counts (k+4)*div+ofs for lengths 4..8
    for (int k = 0; k < 5; k++) begin
      op.set_sym(k == 0 ? MCT_SYM_C39 : k == 1 ? MCT_SYM_I25 :
        k == 2 ? MCT_SYM_CBR : k == 3 ? MCT_SYM_C128 : MCT_SYM_EAN128);
      elem <= k == 0 ? 8'd30 : k == 1 ? 8'd11 : k == 2 ? 8'd32 :
        k == 3 ? 8'd31 : 8'd34;
      @(negedge clock);
      chk("dlen", 6'(k + 4), dlen);
    end
    done("length");
    @(posedge clock);
    cmp_en <= 1'b1;
    wr_ref(1'b0, 8'h41);
    rd(MCT_SYM_C39, 8'h41, 5);
    chk("rout", rsel, r_seen);
    chk("beep", 1'b1, b_seen);
    chk("lamp", 1'b1, lamp);
    chk("hvld", 32'd5, h_n);
    chk("hchar", 8'h45, hchar);
    n0 = ncnt;
    clr();
    op.set_pulse(1'b1);
    repeat (3) @(negedge clock);
    chk("lamp", 1'b1, lamp);
    op.set_pulse(1'b0);
    repeat (4) @(negedge clock);
    chk("lamp", 1'b0, lamp);
    chk("rout", 3'h0, r_seen);
    chk("ncnt", n0 + 32'h1, ncnt);
    wr_ref(1'b1, 8'h50);
    ref2_en <= 1'b1;
    rd(MCT_SYM_C39, 8'h50, 5);
    chk("rout", rsel, r_seen);
    done("match");
    @(posedge clock);
    filt_en <= 1'b1;
    rd(MCT_SYM_C39, 8'h61, 5);
    chk("hpass", 1'b0, hpass);
    rd(MCT_SYM_C39, 8'h41, 5);
    chk("hpass", 1'b1, hpass);
    done("filter");
    // fixed lengths: a read only counts while its length is enabled
    for (int k = 0; k < 4; k++) begin
      fl = k == 0 ? 12 : k == 1 ? 7 : k == 2 ? 11 : 5;
      @(posedge clock);
      fix_en <= 4'hf;
      n0 = gcnt;
      rd(k < 2 ? MCT_SYM_EAN : MCT_SYM_UPC, 8'h30, fl);
      chk("gcnt", n0 + 32'h1, gcnt);
      @(posedge clock);
      fix_en <= ~(4'h1 << k);
      n0 = ncnt;
      rd(k < 2 ? MCT_SYM_EAN : MCT_SYM_UPC, 8'h30, fl);
      chk("ncnt", n0 + 32'h1, ncnt);
    end
    done("fixed");
    @(posedge clock);
    fix_en <= 4'hf;
    cmp_en <= 1'b0;
    filt_en <= 1'b0;
    ref2_en <= 1'b0;
    teach_mode <= MCT_TEACH_DYNAMIC;
    op.set_teach(1'b1);
    repeat (3) @(posedge clock);
    op.set_teach(1'b0);
    rd(MCT_SYM_C39, 8'h30, 5);
    op.set_teach(1'b1);
    repeat (8) @(negedge clock);
    chk("nv", 1'b1, nv_seen);
    @(posedge clock);
    rsel <= 3'h5;
    bsel <= 1'b0;
    rd(MCT_SYM_C39, 8'h30, 5);
    chk("rout", rsel, r_seen);
    chk("beep", 1'b0, b_seen);
    rd(MCT_SYM_C39, 8'h41, 5);
    chk("rout", 3'h0, r_seen);
    done("dynamic");
    @(posedge clock);
    teach_mode <= MCT_TEACH_STATIC;
    cnt_rst <= 1'b1;
    mreads <= 6'h07;
    sym_en <= 10'h3ff & ~(10'h1 << MCT_SYM_I25);
    clr();
    op.set_teach(1'b0);
    repeat (2) @(negedge clock);
    chk("pact", 1'b1, pact);
    chk("mreads", `MCT_STATIC_MULTI, mr_out);
    op.label(MCT_SYM_I25, 8'h31, 6, 1'b1);
    repeat (4) @(negedge clock);
    chk("pact", 1'b0, pact);
    op.set_teach(1'b1);
    repeat (8) @(negedge clock);
    chk("nv", 1'b1, nv_seen);
    chk("dclr", 1'b1, clr_seen);
    chk("mreads", mreads, mr_out);
    rd(MCT_SYM_C39, 8'h41, 5);
    chk("hpass", 1'b0, hpass);
    done("static");
    final_report();
  end
endmodule
`default_nettype wire
